// >>> rtl/cwl_cmd_decoder.sv
// Command decoder for block count, block write, register program, erase, lock and prefix.
`timescale 1ns/100ps
// Overview of operation
// RULE1: Block count command stores low sixteen argument bits; upper half must be zero.
// RULE2: Stored count applies only to the very next multiple-block command.
// RULE3: Single block write carries one fixed 512-byte block at the address.
// RULE4: Multiple write takes blocks until stop command or preset count runs out.
// RULE5: Misaligned write flag reads zero; writes stay within one physical block.
// RULE6: Identity register programs once; hardware blocks every later programming.
// RULE7: Config program changes only the programmable bits of the config register.
// RULE8: Erase start command latches its argument as first erase group address.
// RULE9: Erase end command latches its argument as last erase group address.
// RULE10: Erase command erases selected range with busy response while erasing.
// RULE11: Lock command receives a block to set passwords or lock; busy response.
// RULE12: Lock block length equals the most recently selected block length.
// RULE13: Prefix command carries relative address in upper half, arms security decode.
// RULE14: Security-defined index after the prefix runs the security function instead.
// RULE15: While busy the card holds the data line low, releasing on completion.
// RULE16: Block length select sets length for later block reads and lock.
// RULE17: Host sends erase start, erase end, erase, and waits for busy to end.
// RULE18: Repeated identity program is rejected, register kept, error in response.
module cwl_cmd_decoder
    import cwl_pkg::*;
(
    // Clock and reset.
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    // Decoded command from the frame receiver.
    input  wire logic        cmd_valid_i,
    input  wire logic [5:0]  cmd_index_i,
    input  wire logic [31:0] cmd_arg_i,
    input  wire logic [15:0] card_relative_address_i,
    // Card bus pins.
    input  wire logic        card_clk_i,
    input  wire logic        card_dat_i,
    output logic             card_dat_o,
    output logic             card_dat_oe_o,
    // Answer to the response framer.
    output cwl_resp_s        resp_o,
    // Flash back end.
    output cwl_flash_s       flash_o,
    input  wire logic        flash_done_i,
    output logic             byte_valid_o,
    output logic [7:0]       byte_o,
    output logic [31:0]      erase_first_o,
    output logic [31:0]      erase_last_o,
    // Security function hand-off.
    output logic             sec_valid_o,
    output logic [5:0]       sec_index_o,
    output logic [31:0]      sec_arg_o,
    // Card registers and status.
    output logic [127:0]     card_identity_register_o,
    output logic [127:0]     card_specific_config_register_o,
    output logic             identity_programmed_o,
    output logic [11:0]      block_length_o,
    output logic             misaligned_write_allowed_o,
    output logic             busy_o
);
    cwl_regs_s r_reg;
    cwl_regs_s r_next;
    logic      clk_rise;
    logic      dat_level;

    cwl_pin_sync u_clk_sync (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .pin_i   (card_clk_i),
        .level_o (),
        .rise_o  (clk_rise)
    );

    cwl_pin_sync u_dat_sync (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .pin_i   (card_dat_i),
        .level_o (dat_level),
        .rise_o  ()
    );

    always_comb begin
        r_next            = r_reg;
        r_next.resp       = '0;
        r_next.byte_valid = 1'b0;
        r_next.flash      = r_reg.flash;
        r_next.flash.start = 1'b0;
        r_next.sec_valid  = 1'b0;

        // Data line side: start bit, payload, then busy until the back end is done.
        case (r_reg.st)
            ST_WAIT_START: begin
                if (clk_rise && !dat_level) begin
                    r_next.st      = ST_RX_DATA;
                    r_next.bit_cnt = 15'h0000;
                end
            end
            ST_RX_DATA: begin
                if (clk_rise) begin
                    r_next.byte_sr = {r_reg.byte_sr[6:0], dat_level};
                    r_next.wide    = {r_reg.wide[126:0], dat_level};
                    r_next.bit_cnt = r_reg.bit_cnt + 15'h0001;
                    if (r_reg.bit_cnt[2:0] == 3'h7) begin
                        r_next.byte_valid = 1'b1;
                    end
                    if (r_reg.bit_cnt == r_reg.bit_last) begin
                        r_next.st          = ST_BUSY;
                        r_next.dat_oe      = 1'b1;                        // [RULE15]
                        r_next.flash.start = 1'b1;
                        r_next.flash.op    = r_reg.op;
                        r_next.flash.addr  = r_reg.addr;
                        if (r_reg.op == OP_ID_PROG) begin
                            r_next.id_reg  = {r_reg.wide[126:0], dat_level};
                            r_next.id_done = 1'b1;                        // [RULE6]
                        end
                        if (r_reg.op == OP_CONFIG_PROG) begin
                            r_next.csd_reg = (r_reg.csd_reg & ~CSD_PROG_MASK) |
                                ({r_reg.wide[126:0], dat_level} & CSD_PROG_MASK); // [RULE7]
                        end
                    end
                end
            end
            ST_BUSY: begin
                if (flash_done_i) begin
                    r_next.dat_oe = 1'b0;                                 // [RULE15]
                    r_next.st     = ST_IDLE;
                    if (r_reg.op == OP_WRITE && r_reg.multi) begin
                        // Each block of a run lands at the next aligned slot.
                        r_next.addr = r_reg.addr + BLK_WR_STEP;           // [RULE4]
                        r_next.st   = ST_WAIT_START;
                        if (r_reg.cnt_active) begin
                            r_next.blk_cnt = r_reg.blk_cnt - 16'h0001;
                            if (r_reg.blk_cnt == 16'h0001) begin
                                r_next.st    = ST_IDLE;                   // [RULE4]
                                r_next.multi = 1'b0;
                            end
                        end
                    end
                end
            end
            default: begin
            end
        endcase

        if (cmd_valid_i && cmd_index_i == CMD_GO_IDLE) begin
            // Idle command returns the decoder to rest; programmed registers persist.
            r_next.st         = ST_IDLE;
            r_next.op         = OP_NONE;
            r_next.multi      = 1'b0;
            r_next.cnt_armed  = 1'b0;
            r_next.cnt_active = 1'b0;
            r_next.sec_armed  = 1'b0;
            r_next.dat_oe     = 1'b0;
            r_next.blk_len    = BLK_LEN_RESET;
        end else if (cmd_valid_i) begin
            // Any command consumes a pending count or prefix.
            r_next.cnt_armed = 1'b0;                                      // [RULE2]
            r_next.sec_armed = 1'b0;
            if (r_reg.sec_armed && SEC_CMD_SET[cmd_index_i]) begin
                r_next.sec_valid = 1'b1;                                  // [RULE14]
                r_next.sec_index = cmd_index_i;
                r_next.sec_arg   = cmd_arg_i;
            end else if (cmd_index_i == CMD_STOP) begin
                if (r_reg.multi) begin
                    r_next.multi      = 1'b0;                             // [RULE4]
                    r_next.cnt_active = 1'b0;
                    if (r_reg.st == ST_WAIT_START) begin
                        r_next.st = ST_IDLE;
                    end
                    r_next.resp.valid     = 1'b1;
                    r_next.resp.busy_type = (r_reg.st == ST_BUSY);
                end
            end else if (r_reg.st == ST_IDLE) begin
                r_next.resp.valid = 1'b1;
                case (cmd_index_i)
                    CMD_BLOCK_LEN_SEL: begin
                        if (cmd_arg_i == 32'h0000_0000 ||
                            cmd_arg_i > {20'h00000, BLK_LEN_MAX}) begin
                            r_next.resp.error = 1'b1;
                        end else begin
                            r_next.blk_len = cmd_arg_i[11:0];             // [RULE16]
                        end
                    end
                    CMD_BLOCK_COUNT: begin
                        if (cmd_arg_i[31:COUNT_MSB+1] != 16'h0000) begin
                            r_next.resp.error = 1'b1;
                        end else begin
                            r_next.blk_cnt   = cmd_arg_i[COUNT_MSB:0];    // [RULE1]
                            r_next.cnt_armed = 1'b1;                      // [RULE2]
                        end
                    end
                    CMD_WRITE_SINGLE,
                    CMD_WRITE_MULTI: begin
                        if (cmd_arg_i[BLK_ALIGN_LSB-1:0] != 9'h000) begin
                            r_next.resp.error = 1'b1;                     // [RULE5]
                        end else begin
                            r_next.st       = ST_WAIT_START;
                            r_next.op       = OP_WRITE;
                            r_next.addr     = cmd_arg_i;
                            r_next.bit_last = {BLK_WR_BYTES, 3'h7};       // [RULE3]
                            r_next.multi    = (cmd_index_i == CMD_WRITE_MULTI); // [RULE4]
                            r_next.cnt_active = (cmd_index_i == CMD_WRITE_MULTI) &&
                                r_reg.cnt_armed && (r_reg.blk_cnt != 16'h0000); // [RULE2]
                        end
                    end
                    CMD_ID_PROGRAM: begin
                        if (r_reg.id_done) begin
                            r_next.resp.error = 1'b1;                     // [RULE18]
                        end else begin
                            r_next.st       = ST_WAIT_START;
                            r_next.op       = OP_ID_PROG;
                            r_next.bit_last = {REG128_BYTES, 3'h7};
                            r_next.multi    = 1'b0;
                        end
                    end
                    CMD_CONFIG_PROGRAM: begin
                        r_next.st       = ST_WAIT_START;
                        r_next.op       = OP_CONFIG_PROG;
                        r_next.bit_last = {REG128_BYTES, 3'h7};
                        r_next.multi    = 1'b0;
                    end
                    CMD_ERASE_START: begin
                        r_next.erase_first = cmd_arg_i;                   // [RULE8]
                    end
                    CMD_ERASE_END: begin
                        r_next.erase_last = cmd_arg_i;                    // [RULE9]
                    end
                    CMD_ERASE: begin
                        // No data phase: busy starts at once and lasts for the erase.
                        r_next.resp.busy_type = 1'b1;                     // [RULE10]
                        r_next.st          = ST_BUSY;
                        r_next.op          = OP_ERASE;
                        r_next.multi       = 1'b0;
                        r_next.dat_oe      = 1'b1;                        // [RULE15]
                        r_next.flash.start = 1'b1;
                        r_next.flash.op    = OP_ERASE;
                        r_next.flash.addr  = r_reg.erase_first;
                    end
                    CMD_LOCK_UNLOCK: begin
                        r_next.resp.busy_type = 1'b1;                     // [RULE11]
                        r_next.st       = ST_WAIT_START;
                        r_next.op       = OP_LOCK;
                        r_next.multi    = 1'b0;
                        r_next.bit_last = {r_reg.blk_len, 3'h7} - 15'h0008; // [RULE12]
                    end
                    CMD_SEC_PREFIX: begin
                        if (cmd_arg_i[31:RCA_LSB] == card_relative_address_i) begin
                            r_next.sec_armed = 1'b1;                      // [RULE13]
                        end else begin
                            r_next.resp.valid = 1'b0;
                        end
                    end
                    default: begin
                        // Other indices belong to neighbouring decoders.
                        r_next.resp.valid = 1'b0;
                    end
                endcase
            end
        end

        // Write and register blocks end at byte count minus one bit.
        if (cmd_valid_i && r_reg.st == ST_IDLE &&
            (cmd_index_i == CMD_WRITE_SINGLE || cmd_index_i == CMD_WRITE_MULTI ||
             cmd_index_i == CMD_ID_PROGRAM || cmd_index_i == CMD_CONFIG_PROGRAM) &&
            !(r_reg.sec_armed && SEC_CMD_SET[cmd_index_i])) begin
            r_next.bit_last = r_next.bit_last - 15'h0008;
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            r_reg             <= '0;
            r_reg.st          <= ST_IDLE;
            r_reg.op          <= OP_NONE;
            r_reg.blk_len     <= BLK_LEN_RESET;
            r_reg.id_reg      <= CID_RESET;
            r_reg.csd_reg     <= CSD_RESET;
            r_reg.flash.op    <= OP_NONE;
        end else begin
            r_reg <= r_next;
        end
    end

    // The line is only ever pulled low; the pad releases it when not enabled.
    assign card_dat_o                      = 1'b0;
    assign card_dat_oe_o                   = r_reg.dat_oe;
    assign resp_o                          = r_reg.resp;
    assign flash_o                         = r_reg.flash;
    assign byte_valid_o                    = r_reg.byte_valid;
    assign byte_o                          = r_reg.byte_sr;
    assign erase_first_o                   = r_reg.erase_first;
    assign erase_last_o                    = r_reg.erase_last;
    assign sec_valid_o                     = r_reg.sec_valid;
    assign sec_index_o                     = r_reg.sec_index;
    assign sec_arg_o                       = r_reg.sec_arg;
    assign card_identity_register_o        = r_reg.id_reg;
    assign card_specific_config_register_o = r_reg.csd_reg;
    assign identity_programmed_o           = r_reg.id_done;
    assign block_length_o                  = r_reg.blk_len;
    assign misaligned_write_allowed_o      = MISALIGN_WR_FLAG;                // [RULE5]
    assign busy_o                          = r_reg.dat_oe;
endmodule

// >>> rtl/cwl_pin_sync.sv
// Two-flop synchroniser for one pin with a rising-edge detector behind it.
`timescale 1ns/100ps
module cwl_pin_sync
    import cwl_pkg::*;
(
    // Clock and reset.
    input  wire logic clock_i,
    input  wire logic reset_i,
    // Pin and its synchronised forms.
    input  wire logic pin_i,
    output logic      level_o,
    output logic      rise_o
);
    logic [2:0] sync_reg;

    // Only stage 1 reads stage 0; the edge compare looks at stages 1 and 2.
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            sync_reg <= 3'h0;
        end else begin
            sync_reg <= {sync_reg[1:0], pin_i};
        end
    end

    assign level_o = sync_reg[1];
    assign rise_o  = sync_reg[1] & ~sync_reg[2];
endmodule

// >>> rtl/cwl_pkg.sv
// Shared constants and types of the card write, erase and lock command decoder.
package cwl_pkg;

    // Command indices handled by the decoder.
    localparam logic [5:0] CMD_GO_IDLE        = 6'h00;
    localparam logic [5:0] CMD_STOP           = 6'h0c;
    localparam logic [5:0] CMD_BLOCK_LEN_SEL  = 6'h10;
    localparam logic [5:0] CMD_BLOCK_COUNT    = 6'h17;
    localparam logic [5:0] CMD_WRITE_SINGLE   = 6'h18;
    localparam logic [5:0] CMD_WRITE_MULTI    = 6'h19;
    localparam logic [5:0] CMD_ID_PROGRAM     = 6'h1a;
    localparam logic [5:0] CMD_CONFIG_PROGRAM = 6'h1b;
    localparam logic [5:0] CMD_ERASE_START    = 6'h23;
    localparam logic [5:0] CMD_ERASE_END      = 6'h24;
    localparam logic [5:0] CMD_ERASE          = 6'h26;
    localparam logic [5:0] CMD_LOCK_UNLOCK    = 6'h2a;
    localparam logic [5:0] CMD_SEC_PREFIX     = 6'h37;

    // One bit per command index that has a security meaning after the prefix.
    localparam logic [63:0] SEC_CMD_SET = 64'h0000_0000_0306_0000;

    // Block sizes and field positions.
    localparam logic [11:0] BLK_WR_BYTES      = 12'h200;
    localparam logic [11:0] BLK_LEN_MAX       = 12'h800;
    localparam logic [11:0] BLK_LEN_RESET     = 12'h200;
    localparam logic [11:0] REG128_BYTES      = 12'h010;
    localparam int          BLK_ALIGN_LSB     = 9;
    localparam int          COUNT_MSB         = 15;
    localparam int          RCA_LSB           = 16;
    localparam logic [31:0] BLK_WR_STEP       = 32'h0000_0200;
    localparam logic        MISALIGN_WR_FLAG  = 1'b0;

    // Bits of the card-specific register that the config program may change.
    localparam logic [127:0] CSD_PROG_MASK = 128'h0000_0000_0000_0000_0000_0000_0000_ffff;
    localparam logic [127:0] CSD_RESET     = 128'h0000_0000_0000_0000_0000_0000_0000_0000;
    localparam logic [127:0] CID_RESET     = 128'h0000_0000_0000_0000_0000_0000_0000_0000;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_START,
        ST_RX_DATA,
        ST_BUSY
    } cwl_state_e;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_WRITE,
        OP_ERASE,
        OP_LOCK,
        OP_ID_PROG,
        OP_CONFIG_PROG
    } cwl_op_e;

    // Answer to a command, handed to the response framer.
    typedef struct packed {
        logic valid;
        logic busy_type;
        logic error;
    } cwl_resp_s;

    // Job handed to the flash back end.
    typedef struct packed {
        logic        start;
        cwl_op_e     op;
        logic [31:0] addr;
    } cwl_flash_s;

    typedef struct packed {
        cwl_state_e  st;
        cwl_op_e     op;
        logic [11:0] blk_len;
        logic [15:0] blk_cnt;
        logic        cnt_armed;
        logic        cnt_active;
        logic        multi;
        logic        sec_armed;
        logic        id_done;
        logic [31:0] addr;
        logic [31:0] erase_first;
        logic [31:0] erase_last;
        logic [14:0] bit_cnt;
        logic [14:0] bit_last;
        logic [127:0] wide;
        logic [127:0] id_reg;
        logic [127:0] csd_reg;
        logic [7:0]  byte_sr;
        logic        byte_valid;
        logic        dat_oe;
        cwl_resp_s   resp;
        cwl_flash_s  flash;
        logic        sec_valid;
        logic [5:0]  sec_index;
        logic [31:0] sec_arg;
    } cwl_regs_s;

endpackage

// >>> testbench/card_write_erase_lock_cmd_decoder_tb.sv
// Self-checking bench of the card command decoder.
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module card_write_erase_lock_cmd_decoder_tb
    import cwl_pkg::*;
;
    typedef struct packed {logic [5:0] idx; logic [31:0] arg; logic [1:0] ve;} cwl_row_s;
    logic         clock_i = 1'b0, reset_i = 1'b1, cmd_valid_i = 1'b0, flash_done_i = 1'b0;
    logic [5:0]   cmd_index_i = 6'h00;
    logic [31:0]  cmd_arg_i = 32'h0000_0000;
    logic [15:0]  card_relative_address_i = 16'h1234;
    wire          card_clk_i, host_dat, card_dat_i;
    logic         card_dat_o, card_dat_oe_o, byte_valid_o, sec_valid_o, busy_o;
    logic         identity_programmed_o, misaligned_write_allowed_o, got_sec;
    logic [7:0]   byte_o, bbase = 8'h00;
    logic [5:0]   sec_index_o;
    logic [31:0]  erase_first_o, erase_last_o, sec_arg_o;
    logic [127:0] card_identity_register_o, card_specific_config_register_o, expv;
    logic [11:0]  block_length_o;
    cwl_resp_s    resp_o, got;
    cwl_flash_s   flash_o;
    int           compares = 0, err_count = 0, nbyte = 0;
    cwl_row_s     rows[10] = '{'{CMD_BLOCK_LEN_SEL, 32'h0, 2'h3},
        '{CMD_BLOCK_LEN_SEL, 32'h801, 2'h3}, '{CMD_BLOCK_LEN_SEL, 32'h10, 2'h2},
        '{CMD_BLOCK_COUNT, 32'h1_0003, 2'h3}, '{CMD_BLOCK_COUNT, 32'h3, 2'h2},
        '{CMD_ERASE_START, 32'h1000, 2'h2}, '{CMD_ERASE_END, 32'h3000, 2'h2},
        '{CMD_WRITE_SINGLE, 32'h100, 2'h3}, '{CMD_SEC_PREFIX, 32'h0, 2'h0},
        '{6'h05, 32'h0, 2'h0}};

    cwl_cmd_decoder u_dut (.*);
    cwl_host_model u_host (.card_clk_o(card_clk_i), .dat_o(host_dat));
    assign card_dat_i = card_dat_oe_o ? card_dat_o : host_dat;
    always #2.5 clock_i = ~clock_i;

    always @(posedge clock_i) begin
        if (byte_valid_o === 1'b1) begin
            `CHK("byte", bbase + 8'(nbyte), byte_o)
            nbyte++;
        end
    end
    function automatic logic [127:0] pat(input logic [7:0] b);
        logic [127:0] v;
        for (int k = 0; k < 16; k++) v[127 - 8 * k -: 8] = b + 8'(k);
        return v;
    endfunction
    task automatic cmd(input logic [5:0] idx, input logic [31:0] arg);
        @(posedge clock_i);
        cmd_valid_i <= 1'b1;
        cmd_index_i <= idx;
        cmd_arg_i   <= arg;
        @(posedge clock_i);
        cmd_valid_i <= 1'b0;
        #1;
        got     = resp_o;
        got_sec = sec_valid_o;
    endtask
    task automatic done_wait();
        @(posedge clock_i);
        flash_done_i <= 1'b1;
        @(posedge clock_i);
        flash_done_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        #1;
        `CHK("busy", 1'b0, busy_o)
    endtask
    task automatic xfer(input logic [5:0] idx, input logic [31:0] arg, input int n,
                        input logic [7:0] base, input cwl_op_e op);
        cmd(idx, arg);
        `CHK("xresp", {1'b1, idx == CMD_LOCK_UNLOCK, 1'b0}, got)
        nbyte = 0;
        bbase = base;
        u_host.send_block(n, base);
        repeat (8) @(posedge clock_i);
        #1;
        `CHK("bytes", n, nbyte)
        `CHK("job", {op, 1'b1}, {flash_o.op, busy_o})
        if (op == OP_WRITE) `CHK("waddr", arg, flash_o.addr)
        done_wait();
    endtask
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clock_i);
        reset_i <= 1'b0;
        #1;
        `CHK("reset", {BLK_LEN_RESET, OP_NONE}, {block_length_o, flash_o.op})
        `CHK("misalign", 1'b0, misaligned_write_allowed_o)
        repeat (4) @(posedge clock_i);
        foreach (rows[i]) begin
            cmd(rows[i].idx, rows[i].arg);
            `CHK("resp", rows[i].ve, {got.valid, got.error & got.valid})
        end
        `CHK("blk_len", 12'h010, block_length_o)
        `CHK("range", {32'h1000, 32'h3000}, {erase_first_o, erase_last_o})
        $display("test table done");
        cmd(CMD_SEC_PREFIX, 32'h1234_0000);
        `CHK("pfx", 1'b1, got.valid)
        cmd(CMD_WRITE_SINGLE, 32'h200);
        `CHK("sec", 7'h58, {got_sec, sec_index_o})
        `CHK("sarg", 32'h200, sec_arg_o)
        cmd(CMD_ERASE, 32'h0);
        `CHK("erase", 3'h7, {got.valid, got.busy_type, card_dat_oe_o})
        `CHK("pin", 1'b0, card_dat_o)
        repeat (4) @(posedge clock_i);
        `CHK("eop", {OP_ERASE, 32'h1000}, {flash_o.op, flash_o.addr})
        done_wait();
        $display("test erase done");
        cmd(CMD_WRITE_MULTI, 32'h800);
        cmd(CMD_STOP, 32'h0);
        `CHK("stop", 3'h4, got)
        cmd(CMD_BLOCK_COUNT, 32'h1);
        xfer(CMD_WRITE_MULTI, 32'h400, 512, 8'h30, OP_WRITE);
        cmd(CMD_BLOCK_LEN_SEL, 32'h10);
        `CHK("idle", 1'b1, got.valid)
        xfer(CMD_ID_PROGRAM, 32'h0, 16, 8'ha0, OP_ID_PROG);
        cmd(CMD_ID_PROGRAM, 32'h0);
        `CHK("again", 2'h3, {got.valid, got.error})
        `CHK("id", pat(8'ha0), card_identity_register_o)
        xfer(CMD_CONFIG_PROGRAM, 32'h0, 16, 8'h50, OP_CONFIG_PROG);
        expv = (CSD_RESET & ~CSD_PROG_MASK) | (pat(8'h50) & CSD_PROG_MASK);
        `CHK("csd", expv, card_specific_config_register_o)
        xfer(CMD_LOCK_UNLOCK, 32'h0, 16, 8'h70, OP_LOCK);
        cmd(CMD_GO_IDLE, 32'h0);
        `CHK("go_idle", 13'h1200, {identity_programmed_o, block_length_o})
        $display("test transfers done");
        summarize();
    end
    initial begin
        repeat (90000) @(posedge clock_i);
        err_count++;
        summarize();
    end
endmodule

// >>> testbench/cwl_cmd_decoder_monitor.sv
// Port-level checker of the card command decoder.
`timescale 1ns/100ps
module cwl_cmd_decoder_monitor
    import cwl_pkg::*;
(
    // Clock, reset and command.
    input wire logic         clock_i,
    input wire logic         reset_i,
    input wire logic         cmd_valid_i,
    input wire logic [5:0]   cmd_index_i,
    input wire logic [31:0]  cmd_arg_i,
    // Outputs watched, and the flash done input.
    input wire logic         card_dat_o,
    input wire logic         card_dat_oe_o,
    input wire cwl_resp_s    resp_o,
    input wire cwl_flash_s   flash_o,
    input wire logic [31:0]  erase_first_o,
    input wire logic [31:0]  erase_last_o,
    input wire logic         sec_valid_o,
    input wire logic [5:0]   sec_index_o,
    input wire logic [127:0] card_specific_config_register_o,
    input wire logic         identity_programmed_o,
    input wire logic         misaligned_write_allowed_o,
    input wire logic         busy_o,
    input wire logic         flash_done_i
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    property p_pin_drive;
        busy_o == card_dat_oe_o && !(card_dat_oe_o && card_dat_o) && !misaligned_write_allowed_o;
    endproperty
    a_pin_drive: assert property (p_pin_drive) else $error("Bad data pin drive.");
    property p_count_err;
        cmd_valid_i && cmd_index_i == CMD_BLOCK_COUNT && cmd_arg_i[31:16] != 16'h0000
            |=> !resp_o.valid || resp_o.error;
    endproperty
    a_count_err: assert property (p_count_err) else $error("Bad count accepted.");
    property p_erase_first;
        cmd_valid_i && cmd_index_i == CMD_ERASE_START ##1 resp_o.valid && !resp_o.error
            |-> erase_first_o == $past(cmd_arg_i);
    endproperty
    a_erase_first: assert property (p_erase_first) else $error("Start not latched.");
    property p_erase_last;
        cmd_valid_i && cmd_index_i == CMD_ERASE_END ##1 resp_o.valid && !resp_o.error
            |-> erase_last_o == $past(cmd_arg_i);
    endproperty
    a_erase_last: assert property (p_erase_last) else $error("End not latched.");
    property p_erase_busy;
        cmd_valid_i && cmd_index_i == CMD_ERASE ##1 resp_o.valid |-> resp_o.busy_type
            && card_dat_oe_o ##[0:4] flash_o.start && flash_o.op == OP_ERASE;
    endproperty
    a_erase_busy: assert property (p_erase_busy) else $error("Erase not busy.");
    property p_id_reject;
        cmd_valid_i && cmd_index_i == CMD_ID_PROGRAM && identity_programmed_o
            |=> !resp_o.valid || resp_o.error;
    endproperty
    a_id_reject: assert property (p_id_reject) else $error("Reprogram accepted.");
    property p_csd_fixed;
        (card_specific_config_register_o & ~CSD_PROG_MASK) == (CSD_RESET & ~CSD_PROG_MASK);
    endproperty
    a_csd_fixed: assert property (p_csd_fixed) else $error("Fixed bits changed.");
    property p_sec;
        sec_valid_o |-> $past(cmd_valid_i) && sec_index_o == $past(cmd_index_i)
            && SEC_CMD_SET[$past(cmd_index_i)];
    endproperty
    a_sec: assert property (p_sec) else $error("Bad security decode.");
    property p_busy_release;
        $fell(card_dat_oe_o) |-> $past(flash_done_i) ||
            $past(cmd_valid_i && cmd_index_i == CMD_GO_IDLE);
    endproperty
    a_busy_release: assert property (p_busy_release) else $error("Busy dropped early.");
endmodule
bind cwl_cmd_decoder cwl_cmd_decoder_monitor u_mon (.*);

// >>> testbench/cwl_host_model.sv
// Host side of the card bus: clocks data blocks into the card.
`timescale 1ns/100ps
module cwl_host_model (
    // Card bus as the host drives it.
    output logic card_clk_o,
    output logic dat_o
);
    // The clock stands low and the line rests at its pull-up level outside blocks.
    initial begin
        card_clk_o = 1'b0;
        dat_o      = 1'b1;
    end
    task automatic bit_out(input logic v);
        dat_o = v;
        #32 card_clk_o = 1'b1;
        #32 card_clk_o = 1'b0;
    endtask
    // Start bit, then whole bytes MSB first; the caller picks the length.
    task automatic send_block(input int nbytes, input logic [7:0] base);
        logic [7:0] b;
        bit_out(1'b0);
        for (int k = 0; k < nbytes; k++) begin
            b = base + 8'(k);
            for (int j = 7; j >= 0; j--) bit_out(b[j]);
        end
        dat_o = 1'b1;
    endtask
endmodule
